//--- inc/szap_defines.svh
// address map and field constants for the secure zone access policy
// assumes a 1600-location bit-addressed array behind the block
`ifndef SZAP_DEFINES_SVH
`define SZAP_DEFINES_SVH

`define SZAP_ADDR_W             11
`define SZAP_LEN_W              10
`define SZAP_ADDR_LAST          11'h63F
`define SZAP_ADDR_ZERO          11'h000
`define SZAP_MAKER_FIRST        11'h010
`define SZAP_MAKER_LAST         11'h04F
`define SZAP_CODE_FIRST         11'h050
`define SZAP_CODE_LAST          11'h05F
`define SZAP_ATTEMPT_FIRST      11'h060
`define SZAP_ATTEMPT_LAST       11'h063
`define SZAP_Z3_FIRST           11'h400
`define SZAP_Z3_LAST            11'h5FF
`define SZAP_Z3_WRITE_PERMIT    11'h400
`define SZAP_Z3_READ_PERMIT     11'h401
`define SZAP_ERASE_LIMIT_FUSE   11'h610
`define SZAP_Z3_ERASE_KEY       11'h62F
`define SZAP_Z3_ERASE_TRIGGER   11'h630
`define SZAP_UNUSED_FIRST       11'h631
`define SZAP_WORD_MASK          11'h7F0
`define SZAP_LEN_BIT            10'h001
`define SZAP_LEN_WORD           10'h010
`define SZAP_LEN_Z3             10'h200
`define SZAP_ZONE2_ERASE_CAP    8'h80
`define SZAP_FUSE_BLOWN         1'b0
`define SZAP_ERASE_LEVEL        1'b1
`define SZAP_WRITE_LEVEL        1'b0

`endif

//--- inc/szap_pkg.sv
// types shared by the access policy, its port checker and its bench
// assumes szap_defines.svh is on the include path
`default_nettype none

package szap_pkg;
	typedef enum logic [2:0]
	{
		SZAP_OP_INC   = 3'h0,
		SZAP_OP_RESET = 3'h1,
		SZAP_OP_READ  = 3'h2,
		SZAP_OP_WRITE = 3'h3,
		SZAP_OP_ERASE = 3'h4,
		SZAP_OP_CMP   = 3'h5
	} szap_op_e;

	typedef enum logic [1:0]
	{
		SZAP_ST_IDLE  = 2'h0,
		SZAP_ST_CODE  = 2'h1,
		SZAP_ST_MATCH = 2'h2,
		SZAP_ST_ARMED = 2'h3
	} szap_valid_e;
endpackage

`default_nettype wire

//--- core/szap_addr_counter.sv
// bit address counter with wrap at the top of the map and clear on reset command
// assumes step and clear come from logic on the same clock
`default_nettype none
`include "szap_defines.svh"

module szap_addr_counter
(
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	input  wire logic                    step,
	input  wire logic                    clear,
	output logic [`SZAP_ADDR_W-1:0]      addr
);
	logic [`SZAP_ADDR_W-1:0] addr_reg;
	logic [`SZAP_ADDR_W-1:0] addr_next;

	always_comb
	begin
		addr_next = addr_reg;
		if (clear)
			addr_next = `SZAP_ADDR_ZERO;
		else if (step)
		begin
			if (addr_reg == `SZAP_ADDR_LAST)
				addr_next = `SZAP_ADDR_ZERO;
			else
				addr_next = addr_reg + 11'h001;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			addr_reg <= `SZAP_ADDR_ZERO;
		else
			addr_reg <= addr_next;
	end

	assign addr = addr_reg;
endmodule

`default_nettype wire

//--- core/szap_access_policy.sv
// access policy for the maker zone and application zone three of a secure bit-serial card
// assumes a serial front end on the same clock issues one op per opValid pulse and
// that the bit array behind it reports the addressed bit and the fuse and permit bits
`default_nettype none
`include "szap_defines.svh"

module szap_access_policy
	import szap_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	input  wire logic                    opValid,
	input  wire szap_pkg::szap_op_e      opCode,
	input  wire logic                    opCmpBit,
	output logic                         opReady,
	input  wire logic                    memRdBit,
	input  wire logic                    makerFuse,
	input  wire logic                    issuerFuse,
	input  wire logic                    zone2EraseLimitFuse,
	input  wire logic                    zone3WritePermit,
	input  wire logic                    zone3ReadPermit,
	input  wire logic                    progBusy,
	output logic [`SZAP_ADDR_W-1:0]      bitAddr,
	output logic                         progStart,
	output logic [`SZAP_ADDR_W-1:0]      progAddr,
	output logic [`SZAP_LEN_W-1:0]       progLen,
	output logic                         progLevel,
	output logic                         readValid,
	output logic                         readData,
	output logic                         opDenied,
	output logic                         securityMode2,
	output logic                         securityValidated,
	output logic                         zone3EraseKeyOk,
	output logic                         zone2EraseLimitOn,
	output logic [7:0]                   zone2EraseCap
);
	import szap_pkg::*;

	logic                     take;
	logic                     mode2;
	logic                     blownMaker;
	logic                     blownIssuer;
	logic                     inMaker;
	logic                     inCode;
	logic                     inAttempt;
	logic                     inZone3;
	logic                     isKey;
	logic                     isTrigger;
	logic                     isLimitFuse;
	logic                     isUnused;
	logic                     isWrite;
	logic                     isErase;
	logic                     cmpHit;
	logic                     allowRead;
	logic                     allowProg;
	logic [`SZAP_ADDR_W-1:0]  grantAddr;
	logic [`SZAP_LEN_W-1:0]   grantLen;
	logic                     stepAddr;
	logic                     clearAddr;
	logic [`SZAP_ADDR_W-1:0]  addr;

	szap_valid_e              valid_reg;
	logic                     codeOk_reg;
	logic [`SZAP_ADDR_W-1:0]  armAddr_reg;
	logic                     sv_reg;
	logic                     keyOk_reg;
	logic                     progStart_reg;
	logic [`SZAP_ADDR_W-1:0]  progAddr_reg;
	logic [`SZAP_LEN_W-1:0]   progLen_reg;
	logic                     progLevel_reg;
	logic                     readValid_reg;
	logic                     readData_reg;
	logic                     denied_reg;

	// a new op must wait for the program cycle so the addressed bit is stable;
	// the start pulse blocks too, as busy only rises one edge after it
	assign opReady = !progBusy && !progStart_reg;
	// an op counts only on an edge where the block can accept it
	assign take = opValid && opReady;

	assign blownMaker = (makerFuse == `SZAP_FUSE_BLOWN);
	assign blownIssuer = (issuerFuse == `SZAP_FUSE_BLOWN);
	assign mode2 = blownIssuer;

	assign stepAddr = take && (opCode == SZAP_OP_INC);
	assign clearAddr = take && (opCode == SZAP_OP_RESET);

	szap_addr_counter u_counter
	(
		.clock (clock),
		.arst_n(arst_n),
		.step  (stepAddr),
		.clear (clearAddr),
		.addr  (addr)
	);

	assign inMaker = (addr >= `SZAP_MAKER_FIRST) && (addr <= `SZAP_MAKER_LAST);
	assign inCode = (addr >= `SZAP_CODE_FIRST) && (addr <= `SZAP_CODE_LAST);
	assign inAttempt = (addr >= `SZAP_ATTEMPT_FIRST) && (addr <= `SZAP_ATTEMPT_LAST);
	assign inZone3 = (addr >= `SZAP_Z3_FIRST) && (addr <= `SZAP_Z3_LAST);
	assign isKey = (addr == `SZAP_Z3_ERASE_KEY);
	assign isTrigger = (addr == `SZAP_Z3_ERASE_TRIGGER);
	assign isLimitFuse = (addr == `SZAP_ERASE_LIMIT_FUSE);
	// the spare tail of the map has no cells, so nothing may program there
	assign isUnused = (addr >= `SZAP_UNUSED_FIRST) && (addr <= `SZAP_ADDR_LAST);
	assign isWrite = (opCode == SZAP_OP_WRITE);
	assign isErase = (opCode == SZAP_OP_ERASE);
	assign cmpHit = (opCode == SZAP_OP_CMP) && (opCmpBit == memRdBit);

	// read permission
	always_comb
	begin
		allowRead = 1'b1;
		if (inMaker)
			allowRead = 1'b1;
		else if (inZone3)
			allowRead = zone3ReadPermit || sv_reg;
	end

	// program permission and extent, decided before any cycle starts
	always_comb
	begin
		allowProg = 1'b0;
		grantAddr = addr;
		grantLen = `SZAP_LEN_BIT;
		if (isUnused)
			allowProg = 1'b0;
		else if (inMaker)
		begin
			// either fuse locks the zone for good
			allowProg = sv_reg && !blownMaker && !blownIssuer;
			if (isErase)
			begin
				grantAddr = addr & `SZAP_WORD_MASK;
				grantLen = `SZAP_LEN_WORD;
			end
		end
		else if (inZone3)
		begin
			if (isWrite)
				allowProg = sv_reg && (!mode2 || zone3WritePermit);
			else if (!mode2)
			begin
				// in mode two only the trigger bit may erase the zone
				allowProg = sv_reg;
				grantAddr = `SZAP_Z3_FIRST;
				grantLen = `SZAP_LEN_Z3;
			end
		end
		else if (isTrigger)
		begin
			// no tally kept here: zone three erases are unlimited
			allowProg = isErase && mode2 && sv_reg && keyOk_reg;
			grantAddr = `SZAP_Z3_FIRST;
			grantLen = `SZAP_LEN_Z3;
		end
		else if (isKey)
			allowProg = !mode2 && sv_reg;
		else if (isLimitFuse)
			allowProg = !mode2 && sv_reg;
		else if (inCode || inAttempt)
		begin
			allowProg = inAttempt && (valid_reg != SZAP_ST_IDLE);
			if (isErase)
			begin
				grantAddr = addr & `SZAP_WORD_MASK;
				grantLen = `SZAP_LEN_WORD;
			end
		end
		else
		begin
			// zones outside this block's scope pass through unchanged
			allowProg = 1'b1;
			if (isErase)
			begin
				grantAddr = addr & `SZAP_WORD_MASK;
				grantLen = `SZAP_LEN_WORD;
			end
		end
	end

	// security code comparison, then write and erase of one attempt bit
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valid_reg <= SZAP_ST_IDLE;
			codeOk_reg <= 1'b0;
			armAddr_reg <= `SZAP_ADDR_ZERO;
		end
		else if (take)
		begin
			case (valid_reg)
				SZAP_ST_IDLE:
				begin
					if (opCode == SZAP_OP_CMP && addr == `SZAP_CODE_FIRST)
					begin
						valid_reg <= SZAP_ST_CODE;
						codeOk_reg <= cmpHit;
					end
				end
				SZAP_ST_CODE:
				begin
					// anything but a step between compares breaks the sequence
					if (opCode == SZAP_OP_CMP && inCode)
					begin
						codeOk_reg <= codeOk_reg && cmpHit;
						if (addr == `SZAP_CODE_LAST)
							valid_reg <= (codeOk_reg && cmpHit) ? SZAP_ST_MATCH
								: SZAP_ST_IDLE;
					end
					else if (opCode != SZAP_OP_INC)
						valid_reg <= SZAP_ST_IDLE;
				end
				SZAP_ST_MATCH:
				begin
					if (isWrite && inAttempt && memRdBit)
					begin
						valid_reg <= SZAP_ST_ARMED;
						armAddr_reg <= addr;
					end
					else if (opCode != SZAP_OP_INC)
						valid_reg <= SZAP_ST_IDLE;
				end
				SZAP_ST_ARMED:
				begin
					if (opCode != SZAP_OP_INC)
						valid_reg <= SZAP_ST_IDLE;
				end
				default:
					valid_reg <= SZAP_ST_IDLE;
			endcase
		end
	end

	// flags live until power-down; only the power-on reset clears them
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			sv_reg <= 1'b0;
		else if (take && isErase && valid_reg == SZAP_ST_ARMED && addr == armAddr_reg)
			sv_reg <= 1'b1;
	end

	// the key is a single bit, so one matching compare verifies it
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			keyOk_reg <= 1'b0;
		else if (take && isKey && cmpHit)
			keyOk_reg <= 1'b1;
	end

	// program request toward the array, one pulse per granted op
	// extent and level then hold after the pulse for the array to use
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			progStart_reg <= 1'b0;
			progAddr_reg <= `SZAP_ADDR_ZERO;
			progLen_reg <= `SZAP_LEN_BIT;
			progLevel_reg <= `SZAP_ERASE_LEVEL;
		end
		else
		begin
			progStart_reg <= take && (isWrite || isErase) && allowProg;
			if (take && (isWrite || isErase) && allowProg)
			begin
				progAddr_reg <= grantAddr;
				progLen_reg <= grantLen;
				progLevel_reg <= isErase ? `SZAP_ERASE_LEVEL : `SZAP_WRITE_LEVEL;
			end
		end
	end

	// read answer; a denied read returns zero, and an attempt bit returns the validation flag
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			readValid_reg <= 1'b0;
			readData_reg <= 1'b0;
			denied_reg <= 1'b0;
		end
		else
		begin
			readValid_reg <= take && (opCode == SZAP_OP_READ);
			denied_reg <= take && ((opCode == SZAP_OP_READ && !allowRead)
				|| ((isWrite || isErase) && !allowProg));
			if (take && opCode == SZAP_OP_READ)
			begin
				// attempt bits report the outcome of validation to the host
				if (inAttempt)
					readData_reg <= sv_reg;
				else
					readData_reg <= allowRead && memRdBit;
			end
		end
	end

	assign bitAddr = addr;
	assign progStart = progStart_reg;
	assign progAddr = progAddr_reg;
	assign progLen = progLen_reg;
	assign progLevel = progLevel_reg;
	assign readValid = readValid_reg;
	assign readData = readData_reg;
	assign opDenied = denied_reg;
	assign securityMode2 = mode2;
	assign securityValidated = sv_reg;
	assign zone3EraseKeyOk = keyOk_reg;
	// zone-two tally lives elsewhere; this only tells it whether to count and up to what cap
	assign zone2EraseLimitOn = mode2 && !(zone2EraseLimitFuse == `SZAP_FUSE_BLOWN);
	assign zone2EraseCap = `SZAP_ZONE2_ERASE_CAP;
endmodule

`default_nettype wire

//--- testbench/szap_policy_properties.sv
// port-level assertions for the access policy
// assumes one clock domain with asynchronous active-low reset
`default_nettype none
`include "szap_defines.svh"

module szap_policy_checker
	import szap_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    arst_n,
	input wire logic                    opValid,
	input wire szap_pkg::szap_op_e      opCode,
	input wire logic                    opReady,
	input wire logic                    makerFuse,
	input wire logic                    issuerFuse,
	input wire logic                    zone2EraseLimitFuse,
	input wire logic                    zone3WritePermit,
	input wire logic                    progBusy,
	input wire logic [`SZAP_ADDR_W-1:0] bitAddr,
	input wire logic                    progStart,
	input wire logic                    readValid,
	input wire logic                    opDenied,
	input wire logic                    securityMode2,
	input wire logic                    securityValidated,
	input wire logic                    zone2EraseLimitOn,
	input wire logic [7:0]              zone2EraseCap
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire logic go  = opValid && opReady;
	wire logic inc = go && opCode == SZAP_OP_INC;
	wire logic mz  = bitAddr >= `SZAP_MAKER_FIRST && bitAddr <= `SZAP_MAKER_LAST;
	wire logic z3  = bitAddr >= `SZAP_Z3_FIRST && bitAddr <= `SZAP_Z3_LAST;
	wire logic md  = go && (opCode == SZAP_OP_WRITE || opCode == SZAP_OP_ERASE);

	property p_mode; securityMode2 == !issuerFuse; endproperty
	a_mode: assert property (p_mode) else $error("mode flag wrong");
	property p_limit;
		zone2EraseLimitOn == (!issuerFuse && zone2EraseLimitFuse) && zone2EraseCap == 8'h80;
	endproperty
	a_limit: assert property (p_limit) else $error("erase limit wrong");
	property p_wrap; inc && bitAddr == `SZAP_ADDR_LAST |=> bitAddr == `SZAP_ADDR_ZERO; endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");
	property p_step; inc && bitAddr != `SZAP_ADDR_LAST |=> bitAddr == $past(bitAddr) + 11'h001;
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_clr; go && opCode == SZAP_OP_RESET |=> bitAddr == `SZAP_ADDR_ZERO; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_mzrd; go && opCode == SZAP_OP_READ && mz |=> readValid && !opDenied; endproperty
	a_mzrd: assert property (p_mzrd) else $error("maker read refused");
	property p_lock; md && mz && !(makerFuse && issuerFuse) |=> opDenied && !progStart;
	endproperty
	a_lock: assert property (p_lock) else $error("locked zone modified");
	property p_nosv; md && mz && !securityValidated |=> opDenied && !progStart; endproperty
	a_nosv: assert property (p_nosv) else $error("modify without validation");
	property p_sticky; securityValidated |=> securityValidated; endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_busy; progBusy |=> !progStart; endproperty
	a_busy: assert property (p_busy) else $error("start while busy");
	property p_z3w;
		go && opCode == SZAP_OP_WRITE && z3 && securityMode2 && !zone3WritePermit
			|=> opDenied && !progStart;
	endproperty
	a_z3w: assert property (p_z3w) else $error("write without permit");
	c_cmp: cover property (go && opCode == SZAP_OP_CMP);
	c_sv: cover property ($rose(securityValidated));
	c_z3: cover property (md && z3);
endmodule

bind szap_access_policy szap_policy_checker i_chk (.clock, .arst_n, .opValid, .opCode, .opReady,
	.makerFuse, .issuerFuse, .zone2EraseLimitFuse, .zone3WritePermit, .progBusy, .bitAddr,
	.progStart, .readValid, .opDenied, .securityMode2, .securityValidated, .zone2EraseLimitOn,
	.zone2EraseCap);

`default_nettype wire

//--- testbench/szap_bit_array_model.sv
// bit array behind the policy: storage, program timing, permit bits
// assumes one program request at a time, flagged by progStart
`default_nettype none

module szap_bit_array_model
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic [10:0] bitAddr,
	input  wire logic        progStart,
	input  wire logic [10:0] progAddr,
	input  wire logic [9:0]  progLen,
	input  wire logic        progLevel,
	output logic             memRdBit,
	output logic             progBusy,
	output logic             zone3WritePermit,
	output logic             zone3ReadPermit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       bits [0:1599];
	logic [1:0] busyCnt;
	initial for (int i = 0; i < 1600; i++) bits[i] = 1'b1;
	assign memRdBit = bits[bitAddr];
	assign zone3WritePermit = bits[1024];
	assign zone3ReadPermit = bits[1025];
	assign progBusy = busyCnt != 2'h0;
	// contents survive reset, like the real cells
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			busyCnt <= 2'h0;
		else if (progStart)
		begin
			busyCnt <= 2'h3;
			for (int i = 0; i < progLen; i++)
				if (progAddr + i < 1600)
					bits[progAddr + i] <= progLevel;
		end
		else if (busyCnt != 2'h0)
			busyCnt <= busyCnt - 2'h1;
	end
endmodule

`default_nettype wire

//--- testbench/secure_zone_access_policy_tb.sv
// self-checking bench for the access policy with a bit array model
// assumes the checker is bound in by its own file
`default_nettype none

module secure_zone_access_policy_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import szap_pkg::*;
	logic clock = 0, arst_n = 0, opValid = 0, opCmpBit = 0;
	logic makerFuse = 1, issuerFuse = 1, zone2EraseLimitFuse = 1;
	szap_op_e opCode = SZAP_OP_INC;
	logic opReady, memRdBit, zone3WritePermit, zone3ReadPermit, progBusy, progStart, progLevel;
	logic readValid, readData, opDenied, securityMode2, securityValidated, zone3EraseKeyOk;
	logic zone2EraseLimitOn, gRv, gRd, gDn, gPs;
	logic [10:0] bitAddr, progAddr;
	logic [9:0]  progLen;
	logic [7:0]  zone2EraseCap;
	int error_cnt = 0, cmp_count = 0, cyc = 0, a, k;
	int mAddr = 0;
	bit mSv = 0, mKey = 0, mSeq = 0;

	szap_access_policy i_dut (.clock, .arst_n, .opValid, .opCode, .opCmpBit, .opReady, .memRdBit,
		.makerFuse, .issuerFuse, .zone2EraseLimitFuse, .zone3WritePermit, .zone3ReadPermit,
		.progBusy, .bitAddr, .progStart, .progAddr, .progLen, .progLevel, .readValid, .readData,
		.opDenied, .securityMode2, .securityValidated, .zone3EraseKeyOk, .zone2EraseLimitOn,
		.zone2EraseCap);
	szap_bit_array_model i_arr (.clock, .arst_n, .bitAddr, .progStart, .progAddr, .progLen,
		.progLevel, .memRdBit, .progBusy, .zone3WritePermit, .zone3ReadPermit);

	initial forever #25 clock = ~clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			error_cnt++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// reference policy from the rules, working on the bench's own address
	function automatic void predict(input szap_op_e c, output bit ok, output int ga,
		output int gl);
		bit m2;
		m2 = !issuerFuse;
		ok = 1;
		ga = mAddr;
		gl = 1;
		if (mAddr >= 1585)
			ok = 0;
		else if (mAddr >= 1024 && mAddr < 1536 && c == SZAP_OP_WRITE)
			ok = mSv && (!m2 || i_arr.bits[1024]);
		else if ((mAddr >= 1024 && mAddr < 1536) || mAddr == 1584)
		begin
			ok = mSv && ((mAddr == 1584) ? (c == SZAP_OP_ERASE && m2 && mKey) : !m2);
			ga = 1024;
			gl = 512;
		end
		else if (mAddr == 1552 || mAddr == 1583)
			ok = mSv && !m2;
		else
		begin
			if (mAddr >= 16 && mAddr < 80)
				ok = mSv && makerFuse && issuerFuse;
			else if (mAddr >= 80 && mAddr < 100)
				ok = mAddr >= 96 && mSeq;
			if (c == SZAP_OP_ERASE)
			begin
				ga = mAddr / 16 * 16;
				gl = 16;
			end
		end
	endfunction

	// one request, answer held against the model one edge later, then wait out programming
	task automatic op(input szap_op_e c, input logic b);
		bit ok;
		bit rOk;
		bit eRd;
		int ga;
		int gl;
		predict(c, ok, ga, gl);
		rOk = mAddr < 1024 || mAddr > 1535 || i_arr.bits[1025] || mSv;
		eRd = (mAddr >= 96 && mAddr < 100) ? mSv : (rOk && i_arr.bits[mAddr]);
		if (c == SZAP_OP_CMP && mAddr == 1583 && b == i_arr.bits[1583])
			mKey = 1;
		if (c == SZAP_OP_INC)
			mAddr = (mAddr == 1599) ? 0 : mAddr + 1;
		else if (c == SZAP_OP_RESET)
			mAddr = 0;
		opCode = c;
		opCmpBit = b;
		opValid = 1;
		@(posedge clock);
		#1 opValid = 0;
		{gRv, gRd, gDn, gPs} = {readValid, readData, opDenied, progStart};
		if (c == SZAP_OP_READ)
			chk({gRv, gDn, gRd}, {1'b1, !rOk, eRd});
		else if (c == SZAP_OP_WRITE || c == SZAP_OP_ERASE)
			chk({gDn, gPs}, {!ok, ok});
		if (gPs && ok)
		begin
			chk(progAddr, ga[10:0]);
			chk({progLevel, progLen}, {c == SZAP_OP_ERASE, gl[9:0]});
		end
		@(posedge clock);
		#1;
		while (!opReady) @(posedge clock) #1;
		chk(bitAddr, mAddr[10:0]);
	endtask

	task automatic goTo(input int n);
		op(SZAP_OP_RESET, 0);
		repeat (n) op(SZAP_OP_INC, 0);
	endtask

	task automatic validate(input logic bad);
		goTo(80);
		for (k = 0; k < 16; k++)
		begin
			op(SZAP_OP_CMP, i_arr.bits[80 + k] ^ (bad && k == 0));
			op(SZAP_OP_INC, 0);
		end
		if (bad) op(SZAP_OP_INC, 0);
		mSeq = !bad;
		op(SZAP_OP_WRITE, 0);
		op(SZAP_OP_ERASE, 0);
		mSv = mSv || !bad;
		mSeq = 0;
	endtask

	initial
	begin
		a = $urandom(32'hA462);
		repeat (6) @(posedge clock);
		#1 arst_n = 1;
		for (k = 80; k < 96; k++) i_arr.bits[k] = 1'($urandom);
		i_arr.bits[1583] = 1'($urandom);
		chk(bitAddr, 0);
		chk({securityValidated, zone3EraseKeyOk}, 0);
		a = 16 + $urandom % 64;
		goTo(a);
		op(SZAP_OP_READ, 0);
		chk({gRv, gDn, gRd}, {2'b10, i_arr.bits[a]});
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs}, 2'b10);
		validate(1);
		chk(securityValidated, 0);
		validate(0);
		chk(securityValidated, 1);
		$display("validation test done");
		goTo(a);
		op(SZAP_OP_WRITE, 0);
		chk({gPs, progLevel, i_arr.bits[a]}, 3'b100);
		chk(progAddr, a);
		makerFuse = 0;
		op(SZAP_OP_ERASE, 0);
		chk({gDn, gPs}, 2'b10);
		makerFuse = 1;
		issuerFuse = 0;
		op(SZAP_OP_ERASE, 0);
		chk({securityMode2, gDn, gPs}, 3'b110);
		issuerFuse = 1;
		op(SZAP_OP_ERASE, 0);
		chk({securityMode2, gPs, progLevel, i_arr.bits[a]}, 4'b0111);
		$display("maker zone test done");
		a = 1024 + $urandom % 512;
		goTo(a);
		op(SZAP_OP_ERASE, 0);
		chk({gPs, progLevel, progAddr}, {2'b11, 11'h400});
		chk(progLen, 512);
		repeat (1552 - a) op(SZAP_OP_INC, 0);
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs}, 2'b01);
		issuerFuse = 0;
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs}, 2'b10);
		issuerFuse = 1;
		repeat (31) op(SZAP_OP_INC, 0);
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs}, 2'b01);
		issuerFuse = 0;
		op(SZAP_OP_ERASE, 0);
		chk({gDn, gPs}, 2'b10);
		repeat (2) op(SZAP_OP_INC, 0);
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs, i_arr.bits[1585]}, 3'b101);
		issuerFuse = 0;
		i_arr.bits[1024] = 0;
		i_arr.bits[1025] = 0;
		goTo(1030);
		op(SZAP_OP_WRITE, 0);
		chk({gDn, gPs}, 2'b10);
		i_arr.bits[1024] = 1;
		op(SZAP_OP_WRITE, 0);
		chk({gPs, progAddr}, {1'b1, 11'h406});
		op(SZAP_OP_READ, 0);
		chk({gRv, gDn, gRd}, 3'b100);
		op(SZAP_OP_ERASE, 0);
		chk({gDn, gPs}, 2'b10);
		for (k = 0; k < 2; k++)
		begin
			zone2EraseLimitFuse = k[0];
			@(posedge clock) #1 chk({zone2EraseLimitOn, zone2EraseCap}, {k[0], 8'h80});
		end
		goTo(1583);
		op(SZAP_OP_CMP, i_arr.bits[1583]);
		chk(zone3EraseKeyOk, 1);
		op(SZAP_OP_INC, 0);
		for (k = 0; k < 3; k++)
		begin
			i_arr.bits[1030] = 0;
			op(SZAP_OP_ERASE, 0);
			chk({gPs, progLevel, progAddr}, {2'b11, 11'h400});
			chk({progLen, i_arr.bits[1030]}, {10'h200, 1'b1});
		end
		$display("zone three test done");
		goTo(1599);
		op(SZAP_OP_INC, 0);
		chk(bitAddr, 0);
		op(SZAP_OP_INC, 0);
		op(SZAP_OP_RESET, 0);
		chk(bitAddr, 0);
		op(SZAP_OP_INC, 0);
		arst_n = 0;
		mSv = 0;
		mKey = 0;
		mAddr = 0;
		@(posedge clock);
		#1 arst_n = 1;
		chk({securityValidated, zone3EraseKeyOk}, 0);
		chk(bitAddr, 0);
		op(SZAP_OP_INC, 0);
		$display("counter and reset test done");
		conclude();
	end
endmodule

`default_nettype wire
